// >>> rtc_pkg.sv
// Shared constants and types for the real-time clock block
package rtc_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CLOCK_CONTROL = 8'h00;
  localparam logic [7:0] OFS_ALARM_CONTROL = 8'h04;
  localparam logic [7:0] OFS_TIME_VALUE = 8'h08;
  localparam logic [7:0] OFS_DATE_VALUE = 8'h0c;
  localparam logic [7:0] OFS_ALARM_TIME = 8'h10;
  localparam logic [7:0] OFS_ALARM_DATE = 8'h14;
  localparam logic [7:0] OFS_UNLOCK = 8'h18;
  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CAL_LSB = 16;
  localparam int CAL_W = 10;
  localparam int ON_BIT = 15;
  localparam int STOP_IN_IDLE_BIT = 13;
  localparam int SEL_BIT = 7;
  localparam int OSC_BIT = 6;
  localparam int WREN_BIT = 3;
  localparam int VSYNC_BIT = 2;
  localparam int HALF_BIT = 1;
  localparam int OE_BIT = 0;
  localparam int AEN_BIT = 15;
  localparam int CHIME_BIT = 14;
  localparam int PIV_BIT = 13;
  localparam int ASYNC_BIT = 12;
  localparam int MASK_LSB = 8;
  localparam int MASK_W = 4;
  localparam int COUNT_W = 8;
  localparam logic [31:0] TIME_MASK = 32'h3f7f7f00;
  localparam logic [31:0] DATE_MASK = 32'hff1f3f07;
  localparam logic [31:0] ALARM_DATE_MASK = 32'h001f3f07;
  localparam logic [31:0] SEC_UNIT_MASK = 32'h00000f00;
  localparam logic [31:0] SEC_MASK = 32'h00007f00;
  localparam logic [31:0] MIN_UNIT_MASK = 32'h000f7f00;
  localparam logic [31:0] MIN_MASK = 32'h007f7f00;
  localparam logic [31:0] WDAY_MASK = 32'h00000007;
  localparam logic [31:0] DAY_MASK = 32'h00003f00;
  localparam logic [31:0] MONTH_DAY_MASK = 32'h001f3f00;
  // ****************************************************************
  // Reset values and unlock keys
  // ****************************************************************
  localparam logic [31:0] TIME_RESET = 32'h00000000;
  localparam logic [31:0] DATE_RESET = 32'h00010106;
  localparam logic [31:0] KEY_FIRST = 32'haa996655;
  localparam logic [31:0] KEY_SECOND = 32'h556699aa;
  // ****************************************************************
  // Calendar limits in BCD
  // ****************************************************************
  localparam logic [7:0] LAST_SEC = 8'h59;
  localparam logic [7:0] LAST_MIN = 8'h59;
  localparam logic [7:0] LAST_HOUR = 8'h23;
  localparam logic [7:0] LAST_MONTH = 8'h12;
  localparam logic [7:0] LAST_YEAR = 8'h99;
  localparam logic [7:0] FIRST_DAY = 8'h01;
  localparam logic [2:0] LAST_WDAY = 3'h6;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int TICKS_PER_SEC = 32768;
  localparam int PRESC_W = 15;
  localparam int SYNC_WINDOW = 32;
  localparam logic [14:0] VSYNC_START = 15'(TICKS_PER_SEC - SYNC_WINDOW);
  localparam logic [13:0] ASYNC_START =
    14'(TICKS_PER_SEC / 2 - SYNC_WINDOW);
  localparam int CLK_PERIOD_NS = 100;
  localparam int OSC_TIMEOUT_NS = 100000;
  localparam int OSC_TIMEOUT_CYCLES =
    (OSC_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OSC_CNT_W = 11;
  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [3:0] {
    EVERY_HALF = 4'b0000, EVERY_SECOND = 4'b0001, EVERY_TEN_SEC = 4'b0010,
    EVERY_MINUTE = 4'b0011, EVERY_TEN_MIN = 4'b0100, EVERY_HOUR = 4'b0101,
    EVERY_DAY = 4'b0110, EVERY_WEEK = 4'b0111, EVERY_MONTH = 4'b1000,
    EVERY_YEAR = 4'b1001
  } interval_t;
  typedef enum logic [1:0] {
    UNLOCK_IDLE = 2'b00, UNLOCK_HALF = 2'b01, UNLOCK_OPEN = 2'b10
  } unlock_t;
endpackage

// >>> rtc_osc_monitor.sv
// Crystal input synchroniser, edge detector and running monitor
`timescale 1ns/1ps
`default_nettype none
module rtc_osc_monitor #(
  parameter int TIMEOUT = rtc_pkg::OSC_TIMEOUT_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic xtal_in,
  output logic rtc_tick,
  output logic running
);
  import rtc_pkg::*;
  localparam logic [OSC_CNT_W-1:0] LIMIT = OSC_CNT_W'(TIMEOUT);
  typedef struct packed {
    logic meta;
    logic stable;
    logic prev;
    logic tick;
    logic running;
    logic [OSC_CNT_W-1:0] idle;
  } osc_state_t;
  osc_state_t state;
  osc_state_t next_state;

  always_comb begin
    next_state = state;
    next_state.meta = xtal_in;
    next_state.stable = state.meta;
    next_state.prev = state.stable;
    next_state.tick = state.stable & ~state.prev;
    if (next_state.tick) begin
      next_state.idle = '0;
    end else if (state.idle != LIMIT) begin
      next_state.idle = state.idle + 1'b1;
    end
    next_state.running = (state.idle != LIMIT);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign rtc_tick = state.tick;
  assign running = state.running;
endmodule
`default_nettype wire

// >>> rtc_calendar.sv
// Time and date counters held in packed BCD register layout
`timescale 1ns/1ps
`default_nettype none
module rtc_calendar (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sec_tick,
  input wire logic time_wr,
  input wire logic date_wr,
  input wire logic [31:0] wdata,
  output logic [31:0] time_word,
  output logic [31:0] date_word
);
  import rtc_pkg::*;
  typedef struct packed {
    logic [31:0] time_v;
    logic [31:0] date_v;
  } cal_state_t;
  cal_state_t state;
  cal_state_t next_state;
  logic [7:0] sec, minute, hour, day, month, year;
  logic [2:0] wday;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      return {v[7:4] + 4'h1, 4'h0};
    end
    return v + 8'h01;
  endfunction

  // Leap test on a BCD year: tens odd needs 2 or 6, tens even 0, 4 or 8
  function automatic logic [7:0] last_day(input logic [7:0] m,
                                          input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6) :
                  (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    case (m)
      8'h02: last_day = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
      default: last_day = 8'h31;
    endcase
  endfunction

  always_comb begin
    next_state = state;
    sec = {1'b0, state.time_v[14:8]};
    minute = {1'b0, state.time_v[22:16]};
    hour = {2'b00, state.time_v[29:24]};
    day = {2'b00, state.date_v[13:8]};
    month = {3'b000, state.date_v[20:16]};
    year = state.date_v[31:24];
    wday = state.date_v[2:0];
    if (sec_tick) begin
      if (sec == LAST_SEC) begin
        sec = 8'h00;
        if (minute == LAST_MIN) begin
          minute = 8'h00;
          if (hour == LAST_HOUR) begin
            hour = 8'h00;
            wday = (wday == LAST_WDAY) ? 3'h0 : wday + 3'h1;
            if (day == last_day(month, year)) begin
              day = FIRST_DAY;
              if (month == LAST_MONTH) begin
                month = FIRST_DAY;
                year = (year == LAST_YEAR) ? 8'h00 : bcd_inc(year);
              end else begin
                month = bcd_inc(month);
              end
            end else begin
              day = bcd_inc(day);
            end
          end else begin
            hour = bcd_inc(hour);
          end
        end else begin
          minute = bcd_inc(minute);
        end
      end else begin
        sec = bcd_inc(sec);
      end
      next_state.time_v = {2'b00, hour[5:0], 1'b0, minute[6:0], 1'b0,
                           sec[6:0], 8'h00};
      next_state.date_v = {year, 3'b000, month[4:0], 2'b00, day[5:0],
                           5'b00000, wday};
    end
    if (time_wr) begin
      next_state.time_v = wdata & TIME_MASK;
    end
    if (date_wr) begin
      next_state.date_v = wdata & DATE_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= {TIME_RESET, DATE_RESET};
    end else begin
      state <= next_state;
    end
  end

  assign time_word = state.time_v;
  assign date_word = state.date_v;
endmodule
`default_nettype wire

// >>> rtc_calendar_alarm_control.sv
// Clock and calendar control, calibration, alarm and APB register file
//
// Notes on behaviour
// - Time kept as 24-hour BCD; day, date, month, year calendar.
// - Years 2000 to 2099 with automatic leap-year day count.
// - Time advances on crystal ticks, apart from bus clock.
// - Signed 10-bit calibration adds or removes ticks once a minute.
// - Module enable bit writable only while value writes are enabled.
// - Stop-in-idle freezes bus-side logic in idle; else runs on.
// - Pin shows seconds clock or alarm pulse; driven only when enabled.
// - Status bit shows whether the crystal clock is running.
// - Value write enable gates time and date writes; needs unlock.
// - Read sync flag high when a rollover ripple may hit reads.
// - Half-second flag shows second half; seconds write clears it.
// - Interval select codes from half-second up to yearly.
// - Yearly alarm on February 29 fires only in leap years.
// - Alarm enable clears itself at last event without chime.
// - With chime the repeat count wraps to all ones; else stops.
// - Pulse level writable while alarm off, reads pulse while on.
// - Alarm sync flag high within 32 ticks of half-second rollover.
// - Repeat count decrements each event; N gives N+1 alarms.
// - Seconds, minutes, hours kept as tens and units BCD digits.
`timescale 1ns/1ps
`default_nettype none
module rtc_calendar_alarm_control #(
  parameter int OSC_TIMEOUT = rtc_pkg::OSC_TIMEOUT_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rtc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic xtal_in,
  input wire logic idle_mode,
  output logic pin_out,
  output logic pin_oe
);
  import rtc_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [CAL_W-1:0] cal;
    logic on;
    logic stop_in_idle;
    logic sel;
    logic wren;
    logic oe;
    unlock_t unlock;
    logic [PRESC_W-1:0] presc;
    logic [CAL_W:0] cal_left;
    logic sec_tick;
    logic half_tick;
    logic cmp_sec;
    logic cmp_half;
    logic aen;
    logic chime;
    logic pulse;
    interval_t mask;
    logic [COUNT_W-1:0] count;
    logic [31:0] alarm_time;
    logic [31:0] alarm_date;
    logic vsync;
    logic async_flag;
    logic osc;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pin_out;
    logic pin_oe;
  } ctrl_state_t;

  ctrl_state_t state;
  ctrl_state_t next_state;
  logic rtc_tick;
  logic osc_running;
  logic [31:0] time_word;
  logic [31:0] date_word;
  logic bus_gated;
  logic access_done;
  logic bus_write;
  logic time_wr;
  logic date_wr;
  logic [1:0] step;
  logic [PRESC_W:0] sum;
  logic half_evt;
  logic sec_evt;
  logic hit;
  logic [31:0] rd;
  unlock_t key_next;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    case (a)
      OFS_CLOCK_CONTROL, OFS_ALARM_CONTROL, OFS_TIME_VALUE,
      OFS_DATE_VALUE, OFS_ALARM_TIME, OFS_ALARM_DATE,
      OFS_UNLOCK: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  function automatic logic same(input logic [31:0] a,
                                input logic [31:0] b,
                                input logic [31:0] m);
    return ((a ^ b) & m) == 32'h00000000;
  endfunction

  // ****************************************************************
  // Submodules
  // ****************************************************************
  rtc_osc_monitor #(
    .TIMEOUT(OSC_TIMEOUT)
  ) u_osc (
    .pclk(pclk),
    .presetn(presetn),
    .xtal_in(xtal_in),
    .rtc_tick(rtc_tick),
    .running(osc_running)
  );

  rtc_calendar u_cal (
    .pclk(pclk),
    .presetn(presetn),
    .sec_tick(state.sec_tick),
    .time_wr(time_wr),
    .date_wr(date_wr),
    .wdata(pwdata),
    .time_word(time_word),
    .date_word(date_word)
  );

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  assign bus_gated = state.stop_in_idle & idle_mode;
  assign access_done = psel & penable & state.pready;
  assign bus_write = access_done & pwrite & ~bus_gated;
  assign time_wr = bus_write & (paddr == OFS_TIME_VALUE) & state.wren;
  assign date_wr = bus_write & (paddr == OFS_DATE_VALUE) & state.wren;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_state = state;
    step = 2'h1;
    sum = '0;
    half_evt = 1'b0;
    sec_evt = 1'b0;
    hit = 1'b0;
    rd = 32'h00000000;
    key_next = (pwdata == KEY_FIRST) ? UNLOCK_HALF : UNLOCK_IDLE;

    // Prescaler with calibration spread one tick at a time
    if (state.on && rtc_tick) begin
      if (state.cal_left[CAL_W]) begin
        step = 2'h0;
        next_state.cal_left = state.cal_left + 1'b1;
      end else if (state.cal_left != '0) begin
        step = 2'h2;
        next_state.cal_left = state.cal_left - 1'b1;
      end
      sum = {1'b0, state.presc} + {{(PRESC_W - 1){1'b0}}, step};
      half_evt = sum[PRESC_W-1] ^ state.presc[PRESC_W-1];
      sec_evt = sum[PRESC_W];
      next_state.presc = sum[PRESC_W-1:0];
      if (sec_evt && time_word[14:8] == LAST_SEC[6:0]) begin
        next_state.cal_left = {state.cal[CAL_W-1], state.cal};
      end
    end
    next_state.sec_tick = sec_evt;
    next_state.half_tick = half_evt;
    next_state.cmp_sec = state.sec_tick;
    next_state.cmp_half = state.half_tick;

    // Alarm match, evaluated after the calendar has moved
    case (state.mask)
      EVERY_HALF: begin
        hit = state.cmp_half;
      end
      EVERY_SECOND: begin
        hit = state.cmp_sec;
      end
      EVERY_TEN_SEC: begin
        hit = state.cmp_sec & same(time_word, state.alarm_time,
                                   SEC_UNIT_MASK);
      end
      EVERY_MINUTE: begin
        hit = state.cmp_sec & same(time_word, state.alarm_time, SEC_MASK);
      end
      EVERY_TEN_MIN: begin
        hit = state.cmp_sec & same(time_word, state.alarm_time,
                                   MIN_UNIT_MASK);
      end
      EVERY_HOUR: begin
        hit = state.cmp_sec & same(time_word, state.alarm_time, MIN_MASK);
      end
      EVERY_DAY: begin
        hit = state.cmp_sec & same(time_word, state.alarm_time, TIME_MASK);
      end
      EVERY_WEEK: begin
        hit = state.cmp_sec & same(time_word, state.alarm_time, TIME_MASK) &
              same(date_word, state.alarm_date, WDAY_MASK);
      end
      EVERY_MONTH: begin
        hit = state.cmp_sec & same(time_word, state.alarm_time, TIME_MASK) &
              same(date_word, state.alarm_date, DAY_MASK);
      end
      EVERY_YEAR: begin
        // February 29 only exists in leap years
        hit = state.cmp_sec & same(time_word, state.alarm_time, TIME_MASK) &
              same(date_word, state.alarm_date, MONTH_DAY_MASK);
      end
      default: begin
        hit = 1'b0;
      end
    endcase

    if (state.aen && hit) begin
      next_state.pulse = ~state.pulse;
      if (state.count == '0) begin
        if (state.chime) begin
          next_state.count = '1;
        end else begin
          next_state.aen = 1'b0;
        end
      end else begin
        next_state.count = state.count - 1'b1;
      end
    end

    // Crystal-side status captured for reading
    if (!bus_gated) begin
      next_state.vsync = state.on & (state.presc >= VSYNC_START);
      next_state.async_flag = state.on &
        (state.presc[PRESC_W-2:0] >= ASYNC_START);
      next_state.osc = osc_running;
    end

    // Register writes
    if (time_wr) begin
      next_state.presc = '0;
    end
    if (bus_write) begin
      case (paddr)
        OFS_CLOCK_CONTROL: begin
          next_state.cal = pwdata[CAL_LSB +: CAL_W];
          next_state.stop_in_idle = pwdata[STOP_IN_IDLE_BIT];
          next_state.sel = pwdata[SEL_BIT];
          next_state.oe = pwdata[OE_BIT];
          if (state.wren) begin
            next_state.on = pwdata[ON_BIT];
          end
          if (!pwdata[WREN_BIT]) begin
            next_state.wren = 1'b0;
          end else if (state.unlock == UNLOCK_OPEN) begin
            next_state.wren = 1'b1;
          end
          next_state.unlock = UNLOCK_IDLE;
        end
        OFS_ALARM_CONTROL: begin
          next_state.aen = pwdata[AEN_BIT];
          next_state.chime = pwdata[CHIME_BIT];
          next_state.mask = interval_t'(pwdata[MASK_LSB +: MASK_W]);
          next_state.count = pwdata[COUNT_W-1:0];
          if (!state.aen) begin
            next_state.pulse = pwdata[PIV_BIT];
          end
        end
        OFS_ALARM_TIME: begin
          next_state.alarm_time = pwdata & TIME_MASK;
        end
        OFS_ALARM_DATE: begin
          next_state.alarm_date = pwdata & ALARM_DATE_MASK;
        end
        OFS_UNLOCK: begin
          case (state.unlock)
            UNLOCK_HALF: begin
              next_state.unlock = (pwdata == KEY_SECOND) ? UNLOCK_OPEN :
                                  key_next;
            end
            default: begin
              next_state.unlock = key_next;
            end
          endcase
        end
        default: begin
          next_state.unlock = state.unlock;
        end
      endcase
    end

    // Read data captured in the setup cycle
    next_state.pready = psel & ~penable;
    next_state.pslverr = psel & ~penable & ~is_mapped(paddr);
    if (psel && !penable) begin
      case (paddr)
        OFS_CLOCK_CONTROL: begin
          rd[CAL_LSB +: CAL_W] = state.cal;
          rd[ON_BIT] = state.on;
          rd[STOP_IN_IDLE_BIT] = state.stop_in_idle;
          rd[SEL_BIT] = state.sel;
          rd[OSC_BIT] = state.osc;
          rd[WREN_BIT] = state.wren;
          rd[VSYNC_BIT] = state.vsync & state.on;
          rd[HALF_BIT] = state.presc[PRESC_W-1];
          rd[OE_BIT] = state.oe;
        end
        OFS_ALARM_CONTROL: begin
          rd[AEN_BIT] = state.aen;
          rd[CHIME_BIT] = state.chime;
          rd[PIV_BIT] = state.pulse;
          rd[ASYNC_BIT] = state.async_flag;
          rd[MASK_LSB +: MASK_W] = state.mask;
          rd[COUNT_W-1:0] = state.count;
        end
        OFS_TIME_VALUE: begin
          rd = time_word;
        end
        OFS_DATE_VALUE: begin
          rd = date_word;
        end
        OFS_ALARM_TIME: begin
          rd = state.alarm_time;
        end
        OFS_ALARM_DATE: begin
          rd = state.alarm_date;
        end
        default: begin
          rd = 32'h00000000;
        end
      endcase
      next_state.prdata = rd;
    end

    // Output pin
    next_state.pin_oe = state.oe & state.on;
    next_state.pin_out = state.oe & state.on &
      (state.sel ? state.presc[PRESC_W-1] : state.pulse);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign prdata = state.prdata;
  assign pready = state.pready;
  assign pslverr = state.pslverr;
  assign pin_out = state.pin_out;
  assign pin_oe = state.pin_oe;
endmodule
`default_nettype wire

// >>> rtc_calendar_alarm_control_chk.sv
// Port checker for the clock and calendar control block
`timescale 1ns/1ps
`default_nettype none
module rtc_calendar_alarm_control_chk #(
  parameter int OSC_TIMEOUT = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rtc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic xtal_in,
  input wire logic pin_out,
  input wire logic pin_oe
);
  import rtc_pkg::*;
  logic [7:0] quiet;
  logic last_x;
  logic rd;
  logic ok_adr;
  assign rd = pready && !pwrite && !pslverr;
  assign ok_adr = paddr <= 8'h18 && paddr[1:0] == 2'b00;
  // Cycles since the crystal input last moved
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet <= 8'h00;
      last_x <= 1'b0;
    end else begin
      last_x <= xtal_in;
      quiet <= (xtal_in != last_x) ? 8'h00 : quiet + 8'(quiet != 8'hff);
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_ack; psel && !penable |=> pready; endproperty
  a_ack: assert property (p_ack)
    else $error("no ready");
  property p_ack_one; pready |=> !pready; endproperty
  a_ack_one: assert property (p_ack_one)
    else $error("long ready");
  property p_err; pready |-> pslverr == !ok_adr; endproperty
  a_err: assert property (p_err)
    else $error("bad error flag");
  property p_err_zero; pready && pslverr |-> prdata == 32'h0; endproperty
  a_err_zero: assert property (p_err_zero)
    else $error("error data");
  property p_pin; !pin_oe |-> !pin_out; endproperty
  a_pin: assert property (p_pin)
    else $error("pin while off");
  property p_bcd;
    rd && paddr == 8'h08 |-> prdata[14:12] < 3'd6 && prdata[11:8] < 4'd10
      && prdata[22:20] < 3'd6 && prdata[29:24] <= 6'h23;
  endproperty
  a_bcd: assert property (p_bcd)
    else $error("time not bcd");
  property p_osc;
    rd && paddr == 8'h00 && quiet > OSC_TIMEOUT + 8 |-> !prdata[6];
  endproperty
  a_osc: assert property (p_osc)
    else $error("osc flag stuck");
  property p_vsync; rd && paddr == 8'h00 && prdata[2] |-> prdata[15];
  endproperty
  a_vsync: assert property (p_vsync)
    else $error("sync while off");
endmodule
bind rtc_calendar_alarm_control rtc_calendar_alarm_control_chk #(
  .OSC_TIMEOUT(OSC_TIMEOUT)) chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .xtal_in, .pin_out, .pin_oe);
`default_nettype wire

// >>> rtc_calendar_alarm_control_tb.sv
// Self-checking bench for the clock and calendar control block
`timescale 1ns/1ps
`default_nettype none
module rtc_calendar_alarm_control_tb;
  import rtc_pkg::*;
  typedef struct {logic w; logic i; logic [7:0] a;
    logic [31:0] d; logic [31:0] m; logic [31:0] e; logic x;} row_t;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic xtal_in = 0, idle_mode = 0, run = 1, er;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, prev_rd;
  logic pready, pslverr, pin_out, pin_oe;
  int n_errors = 0, comparisons = 0, cyc = 0;
  row_t rows [25] = '{
    '{0,0,8'h00,0,32'hffffffbf,0,0},
    '{0,0,8'h0c,0,32'hffffffff,DATE_RESET,0},
    '{1,0,8'h08,32'h12345600,0,0,0},
    '{0,0,8'h08,0,32'hffffffff,0,0},
    '{1,0,8'h00,32'h8008,0,0,0},
    '{0,0,8'h00,0,32'h8008,0,0},
    '{1,0,8'h18,KEY_FIRST,0,0,0},
    '{1,0,8'h18,KEY_SECOND,0,0,0},
    '{1,0,8'h00,32'h8,0,0,0},
    '{0,0,8'h00,0,32'h8,32'h8,0},
    '{1,0,8'h00,32'ha009,0,0,0},
    '{1,1,8'h00,32'h03ffa009,0,0,0},
    '{0,1,8'h00,0,32'h03ffa009,32'ha009,0},
    '{1,0,8'h00,32'h01ff8009,0,0,0},
    '{0,0,8'h00,0,32'h03ffa009,32'h01ff8009,0},
    '{1,0,8'h08,32'h23595800,0,0,0},
    '{0,0,8'h08,0,TIME_MASK,32'h23595800,0},
    '{1,0,8'h0c,32'h24022903,0,0,0},
    '{0,0,8'h0c,0,DATE_MASK,32'h24022903,0},
    '{1,0,8'h04,32'h2000,0,0,0},
    '{0,0,8'h04,0,32'hefff,32'h2000,0},
    '{1,0,8'h04,32'hc000,0,0,0},
    '{1,0,8'h04,32'he000,0,0,0},
    '{0,0,8'h04,0,32'hefff,32'hc000,0},
    '{0,0,8'h1c,0,32'hffffffff,0,1}};
  rtc_calendar_alarm_control #(.OSC_TIMEOUT(20)) uut (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .xtal_in,
    .idle_mode, .pin_out, .pin_oe);
  always #50 pclk = ~pclk;
  always @(posedge pclk) if (run) xtal_in <= ~xtal_in;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      conclude();
    end
  end
  // ****************************************************************
  // Bus cycle, compare and verdict
  // ****************************************************************
  task automatic apb(input logic w, logic [7:0] a, logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic conclude();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    foreach (rows[j]) begin
      idle_mode <= rows[j].i;
      apb(rows[j].w, rows[j].a, rows[j].d);
      chk("error flag", {31'h0, rows[j].x}, {31'h0, er});
      if (!rows[j].w) chk("read data", rows[j].e, rd & rows[j].m);
    end
    chk("pin enable", 1, {31'h0, pin_oe});
    chk("pulse pin", 0, {31'h0, pin_out});
    do apb(0, 8'h00, 0); while (rd[1] !== 1'b1);
    repeat (8) @(posedge pclk);
    apb(0, 8'h04, 0);
    do begin
      prev_rd = rd;
      apb(0, 8'h04, 0);
    end while (rd !== prev_rd);
    chk("alarm word", 32'he0ff, rd & 32'hefff);
    chk("pulse pin", 1, {31'h0, pin_out});
    apb(1, 8'h08, 32'h23595800);
    apb(0, 8'h00, 0);
    chk("half flag", 0, {31'h0, rd[1]});
    apb(1, 8'h00, 32'h01ff8089);
    repeat (4) @(posedge pclk);
    chk("seconds pin", 0, {31'h0, pin_out});
    apb(1, 8'h00, 32'h01ff8088);
    repeat (4) @(posedge pclk);
    chk("pin enable", 0, {31'h0, pin_oe});
    apb(1, 8'h00, 0);
    apb(1, 8'h00, 32'h8000);
    apb(0, 8'h00, 0);
    chk("on bit", 0, rd & 32'h8008);
    chk("osc running", 32'h40, rd & 32'h40);
    run <= 0;
    repeat (40) @(posedge pclk);
    apb(0, 8'h00, 0);
    chk("osc stopped", 0, rd & 32'h40);
    conclude();
  end
endmodule
`default_nettype wire
